// ---- verilog/pts_pkg.sv ----
// Package with register map, field layout and reset values of the timer
package pts_pkg;
    // Printed offsets are not all multiples of four: these are indices
    localparam logic [7:0] IDX_FLAGS   = 8'h0c;
    localparam logic [7:0] IDX_COUNT   = 8'h11;
    localparam logic [7:0] IDX_CONTROL = 8'h12;
    localparam logic [7:0] IDX_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_PERIOD  = 8'h92;
    // Field positions
    localparam int MATCH_BIT     = 1;
    localparam int TIMER_ON_BIT  = 2;
    localparam int PRE_LSB       = 0;
    localparam int POST_LSB      = 3;
    // Reset values
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hff;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_FLAGS   = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [6:0] CONTROL_MASK = 7'h7f;
    // Prescale terminal counts (ratio minus one)
    localparam logic [3:0] PRE_DIV1  = 4'h0;
    localparam logic [3:0] PRE_DIV4  = 4'h3;
    localparam logic [3:0] PRE_DIV16 = 4'hf;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Write channel states, Gray coded
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_RESP = 2'h1
    } pts_wr_state_t;
endpackage

// ---- verilog/pts_prescaler.sv ----
// Prescaler turning the instruction clock into count ticks
`timescale 1ns/1ps
module pts_prescaler (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_clear,
    input  wire logic       i_run,
    input  wire logic [1:0] i_select,
    output logic            o_tick
);
    logic [3:0] cnt_r;
    logic [3:0] term;

    // Terminal count from the select bits
    always_comb begin
        if (i_select == 2'h0) begin
            term = pts_pkg::PRE_DIV1;
        end else if (i_select == 2'h1) begin
            term = pts_pkg::PRE_DIV4;
        end else begin
            term = pts_pkg::PRE_DIV16;
        end
    end

    assign o_tick = i_run && (cnt_r >= term);

    // Divider count, cleared by count or control writes and reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            cnt_r <= 4'h0;
        end else if (i_run) begin
            if (o_tick) begin
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ---- verilog/pts_postscaler.sv ----
// Postscaler dividing match events by one to sixteen
`timescale 1ns/1ps
module pts_postscaler (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_clear,
    input  wire logic       i_event,
    input  wire logic [3:0] i_select,
    output logic            o_out
);
    logic [3:0] cnt_r;

    assign o_out = i_event && (cnt_r >= i_select);

    // Event count, cleared by count or control writes and reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            cnt_r <= 4'h0;
        end else if (i_event) begin
            if (o_out) begin
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ---- verilog/pts_timer.sv ----
// Period timer with prescaler, postscaler and AXI4-Lite registers
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module pts_timer (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // AXI4-Lite write address
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [11:0] i_awaddr,
    // AXI4-Lite write data
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    // AXI4-Lite write response
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic [1:0]       o_bresp,
    // AXI4-Lite read address
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [11:0] i_araddr,
    // AXI4-Lite read data
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    // Timer outputs
    output logic             o_match,
    output logic             o_irq
);
    logic [7:0] count_r;
    logic [7:0] period_r;
    logic [6:0] control_r;
    logic [7:0] flags_r;
    logic [7:0] enables_r;
    logic       aw_held_r;
    logic [11:0] aw_addr_r;
    logic       w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    pts_pkg::pts_wr_state_t wr_state_r;
    logic       wr_fire;
    logic [7:0] wr_idx;
    logic       wr_ok;
    logic       wr_lane0;
    logic       wr_count;
    logic       wr_control;
    logic       wr_period;
    logic       wr_flags;
    logic       wr_enables;
    logic       scaler_clear;
    logic       aw_take;
    logic       w_take;
    logic       timer_on;
    logic [1:0] pre_sel;
    logic [3:0] post_sel;
    logic       tick;
    logic       match_now;
    logic       post_out;
    logic [7:0] rd_idx;
    logic [31:0] rd_word;
    logic       rd_err;
    logic       rd_take;

    // Channel takes: an item moves when its valid and ready meet
    assign aw_take = i_awvalid && o_awready;
    assign w_take  = i_wvalid && o_wready;

    // Write address and data may arrive in either order; each is
    // parked here until its partner shows up
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= i_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= i_wdata;
            w_strb_r <= i_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // Address ready, low while an address is held or a response waits;
    // it drops at the take itself so a second address is never swallowed
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_awready <= 1'b0;
        end else begin
            o_awready <= !(aw_held_r || aw_take) &&
                         (wr_state_r == pts_pkg::WR_IDLE) && !wr_fire;
        end
    end

    // Data ready, the same rule for the write data channel
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_wready <= 1'b0;
        end else begin
            o_wready <= !(w_held_r || w_take) &&
                        (wr_state_r == pts_pkg::WR_IDLE) && !wr_fire;
        end
    end

    // Decode of the held write; a write without lane 0 is answered
    // but changes nothing
    assign wr_fire  = aw_held_r && w_held_r &&
                      (wr_state_r == pts_pkg::WR_IDLE);
    assign wr_idx   = aw_addr_r[9:2];
    assign wr_ok    = (aw_addr_r[11:10] == 2'h0) && (aw_addr_r[1:0] == 2'h0)
                      && ((wr_idx == pts_pkg::IDX_FLAGS) ||
                          (wr_idx == pts_pkg::IDX_COUNT) ||
                          (wr_idx == pts_pkg::IDX_CONTROL) ||
                          (wr_idx == pts_pkg::IDX_ENABLES) ||
                          (wr_idx == pts_pkg::IDX_PERIOD));
    assign wr_lane0   = wr_fire && wr_ok && w_strb_r[0];
    assign wr_count   = wr_lane0 && (wr_idx == pts_pkg::IDX_COUNT);
    assign wr_control = wr_lane0 && (wr_idx == pts_pkg::IDX_CONTROL);
    assign wr_period  = wr_lane0 && (wr_idx == pts_pkg::IDX_PERIOD);
    assign wr_flags   = wr_lane0 && (wr_idx == pts_pkg::IDX_FLAGS);
    assign wr_enables = wr_lane0 && (wr_idx == pts_pkg::IDX_ENABLES);

    // Write response channel
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_state_r <= pts_pkg::WR_IDLE;
            o_bvalid   <= 1'b0;
            o_bresp    <= pts_pkg::RESP_OKAY;
        end else begin
            case (wr_state_r)
                pts_pkg::WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_r <= pts_pkg::WR_RESP;
                        o_bvalid   <= 1'b1;
                        o_bresp    <= wr_ok ? pts_pkg::RESP_OKAY
                                            : pts_pkg::RESP_SLVERR;
                    end
                end
                default: begin
                    if (i_bready) begin
                        wr_state_r <= pts_pkg::WR_IDLE;
                        o_bvalid   <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Period register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            period_r <= pts_pkg::RST_PERIOD;
        end else if (wr_period) begin
            period_r <= w_data_r[7:0];
        end
    end

    // Control register, bit 7 not stored
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            control_r <= pts_pkg::RST_CONTROL[6:0];
        end else if (wr_control) begin
            control_r <= w_data_r[6:0] & pts_pkg::CONTROL_MASK;
        end
    end

    // Control fields as the dividers see them
    assign timer_on = control_r[pts_pkg::TIMER_ON_BIT];
    assign pre_sel  = control_r[pts_pkg::PRE_LSB +: 2];
    assign post_sel = control_r[pts_pkg::POST_LSB +: 4];

    // Any count or control write restarts both dividers, so the first
    // period after such a write is a whole one
    assign scaler_clear = wr_count || wr_control;

    // Prescaler: one tick per count step, frozen while the timer is off
    pts_prescaler u_pre (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_clear  (scaler_clear),
        .i_run    (timer_on),
        .i_select (pre_sel),
        .o_tick   (tick)
    );

    // Match when the count already equals the period on a tick
    assign match_now = tick && (count_r == period_r);

    // Count register; control writes do not touch it
    // A count write in the same cycle as a tick wins; that tick is lost
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_r <= pts_pkg::RST_COUNT;
        end else if (wr_count) begin
            count_r <= w_data_r[7:0];
        end else if (match_now) begin
            count_r <= 8'h00;
        end else if (tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    // Postscaler: one pulse per n+1 match events
    pts_postscaler u_post (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_clear  (scaler_clear),
        .i_event  (match_now),
        .i_select (post_sel),
        .o_out    (post_out)
    );

    // Unscaled match pulse for serial port and PWM time base
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_match <= 1'b0;
        end else begin
            o_match <= match_now;
        end
    end

    // Sticky flags, write one to clear, set wins over clear
    // Only the match flag is ever set here; the other bits stay clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flags_r <= pts_pkg::RST_FLAGS;
        end else begin
            if (wr_flags) begin
                flags_r <= flags_r & ~w_data_r[7:0];
            end
            if (post_out) begin
                flags_r[pts_pkg::MATCH_BIT] <= 1'b1;
            end
        end
    end

    // Enable mask
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            enables_r <= pts_pkg::RST_ENABLES;
        end else if (wr_enables) begin
            enables_r <= w_data_r[7:0];
        end
    end

    // Level interrupt from any enabled flag
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flags_r & enables_r);
        end
    end

    // Read address decode over the register indices
    assign rd_idx = i_araddr[9:2];

    // Read word and error flag for the address now offered
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        if (i_araddr[11:10] != 2'h0 || i_araddr[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (rd_idx == pts_pkg::IDX_FLAGS) begin
            rd_word = {24'h000000, flags_r};
        end else if (rd_idx == pts_pkg::IDX_COUNT) begin
            rd_word = {24'h000000, count_r};
        end else if (rd_idx == pts_pkg::IDX_CONTROL) begin
            rd_word = {25'h0000000, control_r};
        end else if (rd_idx == pts_pkg::IDX_ENABLES) begin
            rd_word = {24'h000000, enables_r};
        end else if (rd_idx == pts_pkg::IDX_PERIOD) begin
            rd_word = {24'h000000, period_r};
        end else begin
            rd_err = 1'b1;
        end
    end

    // One read at a time: a take only happens while no data wait
    assign rd_take = i_arvalid && o_arready;

    // Read address ready, low from a take until the data are accepted
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_arready <= 1'b0;
        end else if (o_rvalid) begin
            if (i_rready) begin
                o_arready <= 1'b1;
            end
        end else if (rd_take) begin
            o_arready <= 1'b0;
        end else begin
            o_arready <= 1'b1;
        end
    end

    // Read data valid, held until the master takes it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
        end else if (o_rvalid) begin
            if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end else if (rd_take) begin
            o_rvalid <= 1'b1;
        end
    end

    // Read payload, captured at the take and frozen while it waits
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= pts_pkg::RESP_OKAY;
        end else if (rd_take && !o_rvalid) begin
            o_rdata <= rd_word;
            o_rresp <= rd_err ? pts_pkg::RESP_SLVERR : pts_pkg::RESP_OKAY;
        end
    end
endmodule

// ---- tb/pts_timer_props.sv ----
// Checker for bus handshakes and interrupt behaviour of the period timer
`timescale 1ns/1ps
module pts_timer_props (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic [1:0]  o_bresp,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp,
    input wire logic        o_match,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Handshake refusal, holding and answer latency
    aw_refused_a: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted while a response is pending");
    ar_refused_a: assert property (o_rvalid |-> !o_arready)
        else $error("read accepted while read data is pending");
    bresp_hold_a: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read data dropped before taken");
    write_latency_a: assert property (i_awvalid && o_awready && i_wvalid
        && o_wready |=> !o_bvalid ##1 o_bvalid)
        else $error("write response not two cycles after take");
    read_latency_a: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read data not one cycle after take");
    // Registers are at most eight bits wide, upper bits read zero
    upper_zero_a: assert property (
        o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    // Interrupt holds while no write can reach flags or enables
    irq_sticky_a: assert property ((!i_awvalid && !i_wvalid)[*3]
        ##0 o_irq |=> o_irq)
        else $error("interrupt dropped without a write");
    write_seen_c: cover property (o_bvalid && i_bready);
    irq_rise_c: cover property ($rose(o_irq));
    match_seen_c: cover property (o_match);
endmodule

bind pts_timer pts_timer_props i_pts_timer_props (
    .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
    .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp, .o_match, .o_irq);

// ---- tb/pts_pwm_base.sv ----
// Far side model: PWM time base and shift clock fed by the match pulse
`timescale 1ns/1ps
module pts_pwm_base (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_match,
    output logic [15:0]      o_period,
    output logic             o_shift_clk
);
    logic [15:0] run_r;
    // PWM period measured as cycles between two match pulses
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            run_r    <= 16'h0000;
            o_period <= 16'h0000;
        end else if (i_match) begin
            o_period <= run_r + 16'h0001;
            run_r    <= 16'h0000;
        end else begin
            run_r <= run_r + 16'h0001;
        end
    end
    // Serial shift clock toggles on every unscaled match
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_shift_clk <= 1'b0;
        end else if (i_match) begin
            o_shift_clk <= ~o_shift_clk;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// Testbench driving the period timer over AXI4-Lite
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] A_FLG = {2'h0, pts_pkg::IDX_FLAGS, 2'h0};
    localparam logic [11:0] A_CNT = {2'h0, pts_pkg::IDX_COUNT, 2'h0};
    localparam logic [11:0] A_CTL = {2'h0, pts_pkg::IDX_CONTROL, 2'h0};
    localparam logic [11:0] A_ENA = {2'h0, pts_pkg::IDX_ENABLES, 2'h0};
    localparam logic [11:0] A_PER = {2'h0, pts_pkg::IDX_PERIOD, 2'h0};
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, match, irq;
    logic        sclk, sv;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, got;
    logic [15:0] period;
    int          fail_count = 0, n_compared = 0, cyc_n = 0, m;
    int          div [4] = '{1, 4, 16, 16};

    always #50 i_clk = ~i_clk;

    pts_timer i_pts_timer (.i_clk, .i_rst_n,
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .o_match(match), .o_irq(irq));
    pts_pwm_base i_pts_pwm_base (.i_clk, .i_rst_n, .i_match(match),
        .o_period(period), .o_shift_clk(sclk));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Write one register; address and data offered together
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        while (!(ad && dd)) begin
            @(posedge i_clk);
            if (awvalid && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                dd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge i_clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    // Read one register and compare against the expected word
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge i_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge i_clk); while (rvalid !== 1'b1);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        chk(got, exp);
    endtask
    task automatic wait_match;
        do @(posedge i_clk); while (match !== 1'b1);
    endtask
    task automatic note(input string s);
        $display("test done: %s", s);
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        rdchk(A_FLG, 32'h00);
        rdchk(A_CNT, 32'h00);
        rdchk(A_CTL, 32'h00);
        rdchk(A_ENA, 32'h00);
        rdchk(A_PER, 32'hff);
        rdchk(12'h100, 32'h00);
        chk({30'h0, resp}, {30'h0, pts_pkg::RESP_SLVERR});
        wr(12'h100, 8'h5a);
        chk({30'h0, resp}, {30'h0, pts_pkg::RESP_SLVERR});
        note("reset values and unmapped access");
        wr(A_PER, 8'h05);
        chk({30'h0, resp}, {30'h0, pts_pkg::RESP_OKAY});
        rdchk(A_PER, 32'h05);
        for (int s = 0; s < 4; s++) begin
            wr(A_CTL, 8'h04 | 8'(s));
            repeat (2) wait_match();
            sv = sclk;
            @(posedge i_clk);
            chk({16'h0, period}, 32'(6 * div[s]));
            chk({31'h0, sclk}, {31'h0, ~sv});
        end
        note("prescale ratios and period");
        wr(A_CTL, 8'h10);
        wr(A_FLG, 8'hff);
        wr(A_ENA, 8'h02);
        wr(A_CTL, 8'h14);
        m = 0;
        while (irq !== 1'b1) begin
            @(posedge i_clk);
            if (match === 1'b1)
                m++;
        end
        chk(32'(m), 32'h3);
        rdchk(A_FLG, 32'h02);
        wr(A_CTL, 8'h10);
        wr(A_ENA, 8'h00);
        @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(A_FLG, 32'h02);
        wr(A_ENA, 8'h02);
        @(posedge i_clk);
        chk({31'h0, irq}, 32'h1);
        wr(A_FLG, 8'h02);
        @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(A_FLG, 32'h00);
        note("postscaler and interrupt");
        wr(A_CNT, 8'h03);
        rdchk(A_CNT, 32'h03);
        repeat (20) @(posedge i_clk);
        rdchk(A_CNT, 32'h03);
        wr(A_CTL, 8'hfb);
        rdchk(A_CTL, 32'h7b);
        rdchk(A_CNT, 32'h03);
        note("count write, stop and control layout");
        wrap_up();
    end
endmodule
